// >>> hw/lcdg_bus_if.sv
// Parallel register-select link between host controller and display controller
`timescale 1ns/10ps
`default_nettype none

interface lcdg_bus_if;
    logic register_select;
    logic wr_en;
    logic rd_en;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic rd_valid;

    modport dev (
        input register_select,
        input wr_en,
        input rd_en,
        input wr_data,
        output rd_data,
        output rd_valid
    );

    modport host (
        output register_select,
        output wr_en,
        output rd_en,
        output wr_data,
        input rd_data,
        input rd_valid
    );
endinterface

`default_nettype wire

// >>> hw/lcdg_device.sv
// Display controller end: instruction decode, geometry and address registers
`timescale 1ns/10ps
`default_nettype none
`include "lcdg_params.svh"

module lcdg_device #(
    parameter int EXEC_CYCLES = `LCDG_EXEC_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    lcdg_bus_if.dev bus,
    input wire logic graphic_mode,
    input wire logic cursor_on,
    input wire logic ram_step,
    output logic [3:0] vertical_char_pitch,
    output logic [2:0] horizontal_char_pitch,
    output logic [7:0] chars_per_line,
    output logic [7:0] duty_line_count,
    output logic [3:0] cursor_line,
    output logic [15:0] display_start,
    output logic [15:0] ram_pointer,
    output logic [12:0] screen_width_dots,
    output logic [3:0] cursor_length,
    output logic cursor_row_visible,
    output logic busy
);

    // ************************************************************
    // Helpers
    // ************************************************************

    // Stored fields hold value minus one
    function automatic logic [8:0] plus_one(input logic [7:0] v);
        plus_one = {1'b0, v} + 9'h001;
    endfunction

    // Carry into the high byte when the low byte's top bit falls
    function automatic logic low_msb_fall(input logic old_msb, input logic new_msb);
        low_msb_fall = old_msb & ~new_msb;
    endfunction

    // ************************************************************
    // Instruction register and execute strobe
    // ************************************************************

    lcdg_pkg::lcdg_code_t code_q;
    logic [7:0] busy_cnt_q;
    logic busy_q;
    logic exec;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            code_q <= 4'h0;
        end else if (bus.wr_en && bus.register_select) begin
            code_q <= bus.wr_data[3:0];
        end
    end

    assign exec = bus.wr_en && !bus.register_select && !busy_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_cnt_q <= 8'h00;
            busy_q <= 1'b0;
        end else if (exec) begin
            busy_cnt_q <= 8'(EXEC_CYCLES);
            busy_q <= 1'b1;
        end else if (busy_cnt_q != 8'h00) begin
            busy_cnt_q <= busy_cnt_q - 8'h01;
            busy_q <= (busy_cnt_q != 8'h01);
        end else begin
            busy_q <= 1'b0;
        end
    end

    // ************************************************************
    // Status read
    // ************************************************************

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus.rd_data <= 8'h00;
            bus.rd_valid <= 1'b0;
        end else begin
            bus.rd_valid <= bus.rd_en;
            if (bus.rd_en && bus.register_select) begin
                bus.rd_data <= 8'h00;
                bus.rd_data[`LCDG_BUSY_BIT] <= busy_q;
            end else begin
                // Reads with register select low return zero
                bus.rd_data <= 8'h00;
            end
        end
    end

    // ************************************************************
    // Geometry registers
    // ************************************************************

    logic [7:0] pitch_q;
    logic [7:0] cpl_q;
    logic [7:0] duty_q;
    logic [3:0] curline_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pitch_q <= `LCDG_RST_PITCH;
        end else if (exec && code_q == `LCDG_CODE_PITCH) begin
            pitch_q <= {bus.wr_data[`LCDG_VP_MSB:`LCDG_VP_LSB], 1'b0,
                        bus.wr_data[`LCDG_HP_MSB:`LCDG_HP_LSB]};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpl_q <= `LCDG_RST_CPL;
        end else if (exec && code_q == `LCDG_CODE_CPL) begin
            cpl_q <= bus.wr_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            duty_q <= `LCDG_RST_DUTY;
        end else if (exec && code_q == `LCDG_CODE_DUTY) begin
            duty_q <= bus.wr_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            curline_q <= `LCDG_RST_CURLINE;
        end else if (exec && code_q == `LCDG_CODE_CURLINE) begin
            curline_q <= bus.wr_data[3:0];
        end
    end

    // ************************************************************
    // Address registers
    // ************************************************************

    logic [15:0] start_q;
    logic [15:0] ptr_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_q <= `LCDG_RST_WORD;
        end else if (exec && code_q == `LCDG_CODE_START_LO) begin
            start_q[7:0] <= bus.wr_data;
        end else if (exec && code_q == `LCDG_CODE_START_HI) begin
            start_q[15:8] <= bus.wr_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ptr_q <= `LCDG_RST_WORD;
        end else if (exec && code_q == `LCDG_CODE_PTR_LO) begin
            // The counter ripples like hardware, so a falling low MSB carries
            ptr_q <= {ptr_q[15:8] + {7'h00, low_msb_fall(ptr_q[7], bus.wr_data[7])},
                      bus.wr_data};
        end else if (exec && code_q == `LCDG_CODE_PTR_HI) begin
            ptr_q[15:8] <= bus.wr_data;
        end else if (ram_step) begin
            ptr_q <= ptr_q + 16'h0001;
        end
    end

    // ************************************************************
    // Derived display geometry
    // ************************************************************

    logic [8:0] hp_dots;
    logic [8:0] vp_dots;
    logic [8:0] cp_line;

    assign hp_dots = plus_one({5'h00, pitch_q[`LCDG_HP_MSB:`LCDG_HP_LSB]});
    assign vp_dots = plus_one({4'h0, pitch_q[`LCDG_VP_MSB:`LCDG_VP_LSB]});
    assign cp_line = plus_one({4'h0, curline_q});

    // Pitch drives spacing or bits shown
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            horizontal_char_pitch <= 3'h0;
        end else begin
            horizontal_char_pitch <= pitch_q[`LCDG_HP_MSB:`LCDG_HP_LSB];
        end
    end

    // Vertical pitch ignored in graphic mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vertical_char_pitch <= 4'h0;
        end else if (graphic_mode) begin
            vertical_char_pitch <= 4'h0;
        end else begin
            vertical_char_pitch <= pitch_q[`LCDG_VP_MSB:`LCDG_VP_LSB];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            screen_width_dots <= 13'h0000;
        end else begin
            screen_width_dots <= 13'(hp_dots[3:0] * plus_one(cpl_q));
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cursor_length <= 4'h0;
        end else begin
            cursor_length <= hp_dots[3:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cursor_row_visible <= 1'b0;
        end else begin
            cursor_row_visible <= cursor_on && !graphic_mode && (cp_line <= vp_dots);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ram_pointer <= `LCDG_RST_WORD;
            display_start <= `LCDG_RST_WORD;
            chars_per_line <= 8'h00;
            duty_line_count <= 8'h00;
            cursor_line <= 4'h0;
            busy <= 1'b0;
        end else begin
            ram_pointer <= ptr_q;
            display_start <= start_q;
            chars_per_line <= cpl_q;
            duty_line_count <= duty_q;
            cursor_line <= curline_q;
            busy <= busy_q;
        end
    end

endmodule

`default_nettype wire

// >>> hw/lcdg_host.sv
// Host controller end: AXI4-Lite registers driving the register-select link
`timescale 1ns/10ps
`default_nettype none
`include "lcdg_params.svh"

module lcdg_host (
    input wire logic aclk,
    input wire logic aresetn,
    lcdg_bus_if.host bus,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ************************************************************
    // AXI4-Lite write channel
    // ************************************************************

    logic aw_hold_q;
    logic w_hold_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic do_write;
    lcdg_pkg::lcdg_host_state_t state_q;
    logic seq_busy;

    assign seq_busy = (state_q != lcdg_pkg::LCDG_H_IDLE);
    assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `LCDG_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
            end
            if (do_write) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (awaddr_q == `LCDG_OFS_CMD || awaddr_q == `LCDG_OFS_PTR) begin
                    s_axi_bresp <= `LCDG_RESP_OKAY;
                end else if (awaddr_q == `LCDG_OFS_STATUS) begin
                    s_axi_bresp <= `LCDG_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `LCDG_RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Command sequencer
    // ************************************************************

    logic [3:0] code_q;
    logic [7:0] data_q;
    logic pair_q;
    logic [7:0] high_q;
    logic refused_q;
    logic last_busy_q;
    logic accept;

    // Commands arriving mid-sequence are dropped and flagged
    assign accept = do_write && s_axi_wstrb[1] &&
        (awaddr_q == `LCDG_OFS_CMD || awaddr_q == `LCDG_OFS_PTR);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= lcdg_pkg::LCDG_H_IDLE;
            code_q <= 4'h0;
            data_q <= 8'h00;
            pair_q <= 1'b0;
            high_q <= 8'h00;
            refused_q <= 1'b0;
            last_busy_q <= 1'b0;
            bus.register_select <= 1'b0;
            bus.wr_en <= 1'b0;
            bus.rd_en <= 1'b0;
            bus.wr_data <= 8'h00;
        end else begin
            bus.wr_en <= 1'b0;
            bus.rd_en <= 1'b0;
            if (accept && seq_busy) begin
                refused_q <= 1'b1;
            end
            case (state_q)
                lcdg_pkg::LCDG_H_IDLE: begin
                    if (accept && awaddr_q == `LCDG_OFS_CMD) begin
                        code_q <= wdata_q[`LCDG_CMD_CODE_LSB +: 4];
                        data_q <= wdata_q[`LCDG_CMD_DATA_LSB +: 8];
                        pair_q <= 1'b0;
                        state_q <= lcdg_pkg::LCDG_H_POLL;
                    end else if (accept) begin
                        // Low byte first, high always rewritten
                        code_q <= `LCDG_CODE_PTR_LO;
                        data_q <= wdata_q[7:0];
                        high_q <= wdata_q[15:8];
                        pair_q <= 1'b1;
                        state_q <= lcdg_pkg::LCDG_H_POLL;
                    end
                end
                lcdg_pkg::LCDG_H_POLL: begin
                    bus.register_select <= 1'b1;
                    bus.rd_en <= 1'b1;
                    state_q <= lcdg_pkg::LCDG_H_WAIT;
                end
                lcdg_pkg::LCDG_H_WAIT: begin
                    if (bus.rd_valid) begin
                        last_busy_q <= bus.rd_data[`LCDG_BUSY_BIT];
                        if (bus.rd_data[`LCDG_BUSY_BIT]) begin
                            state_q <= lcdg_pkg::LCDG_H_POLL;
                        end else begin
                            state_q <= lcdg_pkg::LCDG_H_INSTR;
                        end
                    end
                end
                lcdg_pkg::LCDG_H_INSTR: begin
                    bus.register_select <= 1'b1;
                    bus.wr_en <= 1'b1;
                    bus.wr_data <= {4'h0, code_q};
                    state_q <= lcdg_pkg::LCDG_H_DATA;
                end
                lcdg_pkg::LCDG_H_DATA: begin
                    bus.register_select <= 1'b0;
                    bus.wr_en <= 1'b1;
                    bus.wr_data <= data_q;
                    if (pair_q) begin
                        code_q <= `LCDG_CODE_PTR_HI;
                        data_q <= high_q;
                        pair_q <= 1'b0;
                        state_q <= lcdg_pkg::LCDG_H_POLL;
                    end else begin
                        state_q <= lcdg_pkg::LCDG_H_IDLE;
                    end
                end
                default: begin
                    state_q <= lcdg_pkg::LCDG_H_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // AXI4-Lite read channel
    // ************************************************************

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `LCDG_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `LCDG_RESP_OKAY;
                if (s_axi_araddr == `LCDG_OFS_STATUS) begin
                    s_axi_rdata <= {29'h0000_0000, refused_q, last_busy_q, seq_busy};
                end else if (s_axi_araddr == `LCDG_OFS_CMD || s_axi_araddr == `LCDG_OFS_PTR) begin
                    s_axi_rdata <= 32'h0000_0000;
                end else begin
                    s_axi_rresp <= `LCDG_RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// >>> hw/lcdg_params.svh
// Constants for the LCD geometry and address setup block and its host controller
`ifndef LCDG_PARAMS_SVH
`define LCDG_PARAMS_SVH

// Instruction codes
`define LCDG_CODE_PITCH 4'h1
`define LCDG_CODE_CPL 4'h2
`define LCDG_CODE_DUTY 4'h3
`define LCDG_CODE_CURLINE 4'h4
`define LCDG_CODE_START_LO 4'h8
`define LCDG_CODE_START_HI 4'h9
`define LCDG_CODE_PTR_LO 4'hA
`define LCDG_CODE_PTR_HI 4'hB

// Field positions in the pitch byte and the status byte
`define LCDG_VP_MSB 7
`define LCDG_VP_LSB 4
`define LCDG_HP_MSB 2
`define LCDG_HP_LSB 0
`define LCDG_BUSY_BIT 7

// Reset values
`define LCDG_RST_PITCH 8'h77
`define LCDG_RST_CPL 8'h13
`define LCDG_RST_DUTY 8'h4F
`define LCDG_RST_CURLINE 4'h7
`define LCDG_RST_WORD 16'h0000

// Execution time of one instruction
`define LCDG_CLK_PERIOD_NS 10
`define LCDG_EXEC_TIME_NS 50
`define LCDG_EXEC_CYCLES ((`LCDG_EXEC_TIME_NS + `LCDG_CLK_PERIOD_NS - 1) / `LCDG_CLK_PERIOD_NS)

// Host register map (AXI4-Lite byte addresses)
`define LCDG_OFS_CMD 8'h00
`define LCDG_OFS_PTR 8'h04
`define LCDG_OFS_STATUS 8'h08
`define LCDG_CMD_CODE_LSB 0
`define LCDG_CMD_DATA_LSB 8
`define LCDG_RESP_OKAY 2'b00
`define LCDG_RESP_SLVERR 2'b10

`endif

// >>> hw/lcdg_pkg.sv
// Types shared by the two ends of the LCD geometry link
package lcdg_pkg;

    typedef logic [3:0] lcdg_code_t;

    typedef enum logic [4:0] {
        LCDG_H_IDLE = 5'b0_0001,
        LCDG_H_POLL = 5'b0_0010,
        LCDG_H_WAIT = 5'b0_0100,
        LCDG_H_INSTR = 5'b0_1000,
        LCDG_H_DATA = 5'b1_0000
    } lcdg_host_state_t;

endpackage

// >>> tb/lcd_geometry_address_setup_test.sv
// Testbench for both ends of the LCD geometry link
`timescale 1ns/10ps
`default_nettype none
`include "lcdg_params.svh"

`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (a), (e)); end end

module lcd_geometry_address_setup_test;
    logic aclk = 0, aresetn = 0, graphic_mode = 0, cursor_on = 0, ram_step = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rd;
    logic [3:0] wstrb = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [3:0] vp, cl, clen;
    logic [2:0] hp;
    logic [7:0] cpl, duty;
    logic [15:0] dstart, ptr;
    logic [12:0] width;
    logic row_vis, busy;
    logic busy_seen = 0;
    int miscompares = 0, cmp_count = 0;

    always #5 aclk = ~aclk;
    // Busy is only a few cycles wide, so remember that it was ever raised
    always @(posedge aclk) if (busy === 1'b1) busy_seen <= 1'b1;
    lcdg_bus_if link ();
    lcdg_device #(.EXEC_CYCLES(2)) i_lcdg_device (.aclk(aclk), .aresetn(aresetn), .bus(link),
        .graphic_mode(graphic_mode), .cursor_on(cursor_on), .ram_step(ram_step),
        .vertical_char_pitch(vp), .horizontal_char_pitch(hp), .chars_per_line(cpl),
        .duty_line_count(duty), .cursor_line(cl), .display_start(dstart), .ram_pointer(ptr),
        .screen_width_dots(width), .cursor_length(clen), .cursor_row_visible(row_vis),
        .busy(busy));
    lcdg_host i_lcdg_host (.aclk(aclk), .aresetn(aresetn), .bus(link), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    lcdg_link_props i_lcdg_link_props (.aclk(aclk), .aresetn(aresetn),
        .register_select(link.register_select), .wr_en(link.wr_en), .rd_en(link.rd_en),
        .wr_data(link.wr_data), .rd_data(link.rd_data), .rd_valid(link.rd_valid));

    task summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ********************************
    // AXI4-Lite master
    // ********************************
    // Expected response 2'b11 means the response is not checked
    task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1; wvalid <= 1; bready <= 1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (bvalid && bready) begin
                bready <= 0;
                if (er != 2'b11) `CHK(bresp, er)
                break;
            end
            if (++n > 200) begin miscompares++; summarize(); end
        end
    endtask

    task axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 0;
            if (rvalid && rready) begin
                rready <= 0; d = rdata;
                `CHK(rresp, er)
                break;
            end
            if (++n > 200) begin miscompares++; summarize(); end
        end
    endtask

    // Waits for the sequencer to go idle, then for the outputs to settle
    task wait_idle;
        for (int n = 0; n < 50; n++) begin
            axi_rd(`LCDG_OFS_STATUS, `LCDG_RESP_OKAY, rd);
            if (rd[0] === 1'b0) begin repeat (3) @(posedge aclk); return; end
        end
        miscompares++;
        summarize();
    endtask

    task cmd(input logic [3:0] code, input logic [7:0] d);
        axi_wr(`LCDG_OFS_CMD, {16'h0000, d, 4'h0, code}, 4'hF, `LCDG_RESP_OKAY);
        wait_idle();
    endtask

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        repeat (2) @(posedge aclk);
        `CHK({vp, 1'b0, hp, cpl, duty, cl}, 28'h77_134_F7)
        `CHK({dstart, ptr}, 32'h0000_0000)
        // ********************************
        // Geometry and address loads
        // ********************************
        cmd(`LCDG_CODE_PITCH, 8'h75);
        cmd(`LCDG_CODE_CPL, 8'h27);
        cmd(`LCDG_CODE_DUTY, 8'h3F);
        cmd(`LCDG_CODE_CURLINE, 8'h03);
        cmd(`LCDG_CODE_START_LO, 8'hCD);
        cmd(`LCDG_CODE_START_HI, 8'hAB);
        `CHK({vp, hp, clen}, 11'h3_D6)
        `CHK({cpl, duty, cl}, 20'h27_3F_3)
        `CHK(width, 13'h00F0)
        `CHK(dstart, 16'hABCD)
        cursor_on <= 1;
        repeat (3) @(posedge aclk);
        `CHK(row_vis, 1'b1)
        graphic_mode <= 1;
        repeat (3) @(posedge aclk);
        `CHK({vp, row_vis}, 5'h00)
        graphic_mode <= 0;
        cmd(`LCDG_CODE_CURLINE, 8'h0F);
        `CHK({vp, row_vis}, 5'h0E)
        // ********************************
        // Pointer loads, carry and stepping
        // ********************************
        axi_wr(`LCDG_OFS_PTR, 32'h0000_12F0, 4'hF, `LCDG_RESP_OKAY);
        wait_idle();
        `CHK(ptr, 16'h12F0)
        cmd(`LCDG_CODE_PTR_LO, 8'h34);
        `CHK(ptr, 16'h1334)
        cmd(`LCDG_CODE_PTR_HI, 8'h12);
        `CHK(ptr, 16'h1234)
        axi_wr(`LCDG_OFS_PTR, 32'h0000_00FF, 4'hF, `LCDG_RESP_OKAY);
        wait_idle();
        ram_step <= 1;
        @(posedge aclk);
        ram_step <= 0;
        repeat (3) @(posedge aclk);
        `CHK(ptr, 16'h0100)
        // ********************************
        // Refused and unmapped accesses
        // ********************************
        // A write without the data byte lane is dropped without setting the sticky flag
        axi_wr(`LCDG_OFS_CMD, 32'h0000_1108, 4'h1, `LCDG_RESP_OKAY);
        wait_idle();
        `CHK({rd[2], dstart}, 17'h0_ABCD)
        // A command arriving during a pointer pair is refused and flagged
        axi_wr(`LCDG_OFS_PTR, 32'h0000_0100, 4'hF, `LCDG_RESP_OKAY);
        axi_wr(`LCDG_OFS_CMD, 32'h0000_1108, 4'hF, `LCDG_RESP_OKAY);
        wait_idle();
        `CHK({rd[2], dstart}, 17'h1_ABCD)
        `CHK({busy_seen, busy}, 2'b10)
        axi_wr(8'h0C, 32'h0000_0000, 4'hF, `LCDG_RESP_SLVERR);
        axi_rd(8'h0C, `LCDG_RESP_SLVERR, rd);
        summarize();
    end
endmodule

`default_nettype wire

// >>> tb/lcdg_link_props.sv
// Checker for the register-select link between host controller and display controller
`timescale 1ns/10ps
`default_nettype none

module lcdg_link_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic register_select,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ********************************
    // Link sequences
    // ********************************
    sequence s_poll_ok;
        rd_valid && !rd_data[7];
    endsequence
    sequence s_code_wr;
        wr_en && register_select;
    endsequence
    sequence s_data_wr;
        wr_en && !register_select;
    endsequence

    property p_rd_answer;
        rd_en |=> rd_valid;
    endproperty
    property p_rd_cause;
        rd_valid |-> $past(rd_en);
    endproperty
    property p_rd_low_bits;
        rd_valid |-> rd_data[6:0] == 7'h00;
    endproperty
    property p_code_then_data;
        s_code_wr |=> s_data_wr;
    endproperty
    property p_data_after_code;
        s_data_wr |-> $past(wr_en && register_select);
    endproperty
    property p_poll_first;
        // The idle answer is sampled two cycles before the code write is sampled on the link
        s_code_wr |-> $past(rd_valid && !rd_data[7], 2);
    endproperty
    property p_no_overlap;
        !(rd_en && wr_en);
    endproperty
    property p_busy_ends;
        rd_valid && rd_data[7] |-> ##[1:40] s_poll_ok;
    endproperty

    a_rd_answer: assert property (p_rd_answer)
        else $error("status read not answered next cycle");
    a_rd_cause: assert property (p_rd_cause)
        else $error("read answer without request");
    a_rd_low_bits: assert property (p_rd_low_bits)
        else $error("status read has nonzero low bits");
    a_code_then_data: assert property (p_code_then_data)
        else $error("code write not followed by data write");
    a_data_after_code: assert property (p_data_after_code)
        else $error("data write without preceding code write");
    a_poll_first: assert property (p_poll_first)
        else $error("code write without idle status read");
    a_no_overlap: assert property (p_no_overlap)
        else $error("read and write requested together");
    a_busy_ends: assert property (p_busy_ends)
        else $error("busy never seen clear");
endmodule

`default_nettype wire
